/* hw/cai_pkg.sv */
// constants shared by the coincidence / aux / digital-port control block
// assumes a single 40 MHz clock and software access over APB
package cai_pkg;
  // timebase
  localparam int unsigned CAI_CLK_MHZ = 40;
  localparam int unsigned CAI_UNIT_NS = 50;
  localparam int unsigned CAI_TICK_DIV = (CAI_UNIT_NS * CAI_CLK_MHZ) / 1000;
  localparam int unsigned CAI_SEC_S = 1;
  localparam int unsigned CAI_SEC_CYCLES = CAI_SEC_S * CAI_CLK_MHZ * 1_000_000;

  // register byte offsets
  localparam logic [11:0] CAI_OFF_WIN_LEN = 12'h000;
  localparam logic [11:0] CAI_OFF_TMO_LEN = 12'h004;
  localparam logic [11:0] CAI_OFF_START_EN = 12'h008;
  localparam logic [11:0] CAI_OFF_COINC_EN = 12'h00c;
  localparam logic [11:0] CAI_OFF_AUX_IN = 12'h010;
  localparam logic [11:0] CAI_OFF_AUX_OUT = 12'h014;
  localparam logic [11:0] CAI_OFF_DIG_USE = 12'h018;
  localparam logic [11:0] CAI_OFF_DIG_VAL = 12'h01c;
  localparam logic [11:0] CAI_OFF_RUN_CTL = 12'h020;
  localparam logic [11:0] CAI_OFF_RT_PRESET = 12'h024;
  localparam logic [11:0] CAI_OFF_STATUS = 12'h028;
  localparam logic [11:0] CAI_OFF_ELAPSED = 12'h02c;

  // values after reset
  localparam logic [15:0] CAI_RST_WIN_LEN = 16'h0050;
  localparam logic [15:0] CAI_RST_TMO_LEN = 16'h0fa0;
  localparam logic [15:0] CAI_RST_AUX_IN = 16'ha003;
  localparam logic [15:0] CAI_RST_AUX_OUT = 16'h0000;
  localparam logic [8:0] CAI_RST_DIG_USE = 9'h000;
  localparam logic [7:0] CAI_RST_DIG_VAL = 8'h00;
  localparam logic [31:0] CAI_RST_RT_PRESET = 32'h0000_03e8;

  // aux input control fields (index 0 = aux port two, 1 = aux port one)
  localparam int unsigned CAI_AUI_POL = 0;
  localparam int unsigned CAI_AUI_START = 2;
  localparam int unsigned CAI_AUI_COINC = 4;
  localparam int unsigned CAI_AUI_VETO_COINC = 12;
  localparam int unsigned CAI_AUI_VETO_POL = 13;
  localparam int unsigned CAI_AUI_VETO_LATE = 15;
  // aux output control fields
  localparam int unsigned CAI_AUO_SEL_W = 4;
  localparam int unsigned CAI_AUO_OE = 8;
  localparam int unsigned CAI_AUO_MIRROR = 10;
  // digital port usage fields
  localparam int unsigned CAI_DIG_STATUS = 0;
  localparam int unsigned CAI_DIG_INV = 1;
  localparam int unsigned CAI_DIG_TRIG = 2;
  localparam int unsigned CAI_DIG_CLR = 3;
  localparam int unsigned CAI_DIG_COUNT = 6;
  localparam int unsigned CAI_DIG_TRISTATE = 7;
  localparam int unsigned CAI_DIG_PULLDOWN = 8;
  localparam int unsigned CAI_DIG_TRIG_LINE = 6;
  localparam int unsigned CAI_DIG_STAT_LINE = 7;
  // run control fields
  localparam int unsigned CAI_RUN_PRESET_EN = 0;
  localparam int unsigned CAI_RUN_START = 4;
  localparam int unsigned CAI_RUN_STOP = 5;
  localparam int unsigned CAI_RUN_CLEAR = 6;
  // status fields
  localparam int unsigned CAI_STAT_TIMEOUT = 3;

  typedef enum logic [3:0] {
    CAI_SRC_START = 4'h0,
    CAI_SRC_RUN = 4'h1,
    CAI_SRC_ACTIVE = 4'h2,
    CAI_SRC_OK = 4'h3,
    CAI_SRC_DEAD = 4'h4,
    CAI_SRC_ENC_A = 4'h5,
    CAI_SRC_ONE = 4'h6,
    CAI_SRC_ZERO = 4'h7
  } cai_src_t;

  typedef enum logic [2:0] {
    CAI_ST_IDLE = 3'b001,
    CAI_ST_WIN = 3'b010,
    CAI_ST_WAIT = 3'b100
  } cai_state_t;
endpackage

/* hw/cai_top.sv */
// coincidence window, data-ready timeout, aux connectors, digital port and run preset
// assumes converter hit/ready pulses synchronous to sys_clk_i; APB master drives the bus
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cai_top import cai_pkg::*; #(
  parameter int unsigned NCONV = 16,
  parameter int unsigned SEC_CYCLES = CAI_SEC_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NCONV-1:0] conv_hit_i,
  input wire logic [NCONV-1:0] conv_ready_i,
  input wire logic enc_a_i,
  input wire logic veto_i,
  input wire logic [1:0] aux_in_i,
  output logic [1:0] aux_out_o,
  output logic [1:0] aux_oe_o,
  input wire logic [7:0] dig_in_i,
  output logic [7:0] dig_out_o,
  output logic [7:0] dig_oe_o,
  output logic dig_tristate_o,
  output logic dig_pulldown_o,
  output logic go_o,
  output logic clear_o,
  output logic store_o
);
  localparam int unsigned SEC_W = $clog2(SEC_CYCLES);

  cai_state_t st_ff, nxt_st;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic [15:0] win_len_ff, tmo_len_ff, aux_in_ctl_ff, aux_out_ctl_ff;
  logic [NCONV-1:0] start_en_ff, coinc_en_ff;
  logic [8:0] dig_use_ff;
  logic [7:0] dig_val_ff, dig_out_ff, dig_oe_ff;
  logic preset_en_ff, run_ff, timeout_ff, clear_ff, store_ff, trig_prev_ff, veto_prev_ff;
  logic [31:0] rt_preset_ff, elapsed_ff;
  logic [SEC_W-1:0] sec_cnt_ff;
  logic [1:0] tick_cnt_ff, aux_prev_ff, aux_drv_ff, aux_oe_ff, seen_aux_ff;
  logic tick_ff, seen_veto_ff;
  logic [15:0] cnt_ff, len_ff, ticks_ff;
  logic [NCONV-1:0] seen_conv_ff, wait_mask_ff, rdy_seen_ff;

  // apb: one wait state, so pready and prdata both leave flops
  wire acc = psel_i & penable_i;
  wire first = acc & ~pready_ff;
  wire wr = acc & pready_ff & pwrite_i;
  wire hit_win = paddr_i == CAI_OFF_WIN_LEN;
  wire hit_tmo = paddr_i == CAI_OFF_TMO_LEN;
  wire hit_sen = paddr_i == CAI_OFF_START_EN;
  wire hit_coi = paddr_i == CAI_OFF_COINC_EN;
  wire hit_aui = paddr_i == CAI_OFF_AUX_IN;
  wire hit_auo = paddr_i == CAI_OFF_AUX_OUT;
  wire hit_duse = paddr_i == CAI_OFF_DIG_USE;
  wire hit_dval = paddr_i == CAI_OFF_DIG_VAL;
  wire hit_run = paddr_i == CAI_OFF_RUN_CTL;
  wire hit_pre = paddr_i == CAI_OFF_RT_PRESET;
  wire hit_stat = paddr_i == CAI_OFF_STATUS;
  wire hit_ela = paddr_i == CAI_OFF_ELAPSED;
  wire mapped = hit_win | hit_tmo | hit_sen | hit_coi | hit_aui | hit_auo | hit_duse |
                hit_dval | hit_run | hit_pre | hit_stat | hit_ela;
  wire [31:0] conv_pad_sen = {{(32-NCONV){1'b0}}, start_en_ff};
  wire [31:0] conv_pad_coi = {{(32-NCONV){1'b0}}, coinc_en_ff};
  wire [31:0] status_word = {28'h0000000, timeout_ff, st_ff == CAI_ST_WAIT,
                             st_ff == CAI_ST_WIN, run_ff};
  wire [31:0] rd_mux =
    hit_win ? {16'h0000, win_len_ff} :
    hit_tmo ? {16'h0000, tmo_len_ff} :
    hit_sen ? conv_pad_sen :
    hit_coi ? conv_pad_coi :
    hit_aui ? {16'h0000, aux_in_ctl_ff} :
    hit_auo ? {16'h0000, aux_out_ctl_ff} :
    hit_duse ? {23'h000000, dig_use_ff} :
    hit_dval ? {24'h000000, dig_val_ff} :
    hit_run ? {31'h00000000, preset_en_ff} :
    hit_pre ? rt_preset_ff :
    hit_stat ? status_word :
    hit_ela ? elapsed_ff : 32'h00000000;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= first;
      pslverr_ff <= first & ~mapped;
      prdata_ff <= (first & ~pwrite_i) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      win_len_ff <= CAI_RST_WIN_LEN;
      tmo_len_ff <= CAI_RST_TMO_LEN;
      start_en_ff <= '0;
      coinc_en_ff <= '0;
      aux_in_ctl_ff <= CAI_RST_AUX_IN;
      aux_out_ctl_ff <= CAI_RST_AUX_OUT;
      dig_use_ff <= CAI_RST_DIG_USE;
      preset_en_ff <= 1'b0;
      rt_preset_ff <= CAI_RST_RT_PRESET;
    end else if (wr) begin
      if (hit_win) win_len_ff <= pwdata_i[15:0];
      if (hit_tmo) tmo_len_ff <= pwdata_i[15:0];
      if (hit_sen) start_en_ff <= pwdata_i[NCONV-1:0];
      if (hit_coi) coinc_en_ff <= pwdata_i[NCONV-1:0];
      if (hit_aui) aux_in_ctl_ff <= pwdata_i[15:0];
      if (hit_auo) aux_out_ctl_ff <= pwdata_i[15:0];
      if (hit_duse) dig_use_ff <= pwdata_i[8:0];
      if (hit_run) preset_en_ff <= pwdata_i[CAI_RUN_PRESET_EN];
      if (hit_pre) rt_preset_ff <= pwdata_i;
    end
  end

  // 50 ns tick from the 40 MHz clock
  wire tick_wrap = tick_cnt_ff == 2'(CAI_TICK_DIV - 1);
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tick_cnt_ff <= 2'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= tick_wrap ? 2'h0 : tick_cnt_ff + 2'h1;
      tick_ff <= tick_wrap;
    end
  end

  // run gate, triggered start, preset
  wire dig_inv = dig_use_ff[CAI_DIG_INV];
  wire trig_lvl = dig_in_i[CAI_DIG_TRIG_LINE] ^ dig_inv;
  wire trig_rise = trig_lvl & ~trig_prev_ff;
  wire hw_start = dig_use_ff[CAI_DIG_TRIG] & trig_rise & ~run_ff;
  wire sw_start = wr & hit_run & pwdata_i[CAI_RUN_START];
  wire sw_stop = wr & hit_run & pwdata_i[CAI_RUN_STOP];
  wire clear_evt = (wr & hit_run & pwdata_i[CAI_RUN_CLEAR]) |
                   (hw_start & dig_use_ff[CAI_DIG_CLR]);
  wire preset_hit = preset_en_ff & (elapsed_ff >= rt_preset_ff);
  wire nxt_run = run_ff ? ~(sw_stop | preset_hit) : (sw_start | hw_start);
  wire stop_evt = run_ff & ~nxt_run;
  wire sec_wrap = sec_cnt_ff == SEC_W'(SEC_CYCLES - 1);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      run_ff <= 1'b0;
      clear_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      clear_ff <= clear_evt;
      trig_prev_ff <= trig_lvl;
    end
  end

  // elapsed time keeps running over stop/start until cleared
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || clear_evt) begin
      sec_cnt_ff <= '0;
      elapsed_ff <= 32'h00000000;
    end else if (run_ff) begin
      sec_cnt_ff <= sec_wrap ? '0 : sec_cnt_ff + SEC_W'(1);
      if (sec_wrap) elapsed_ff <= elapsed_ff + 32'h00000001;
    end
  end

  // a software write of the value overrides the increment of the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) dig_val_ff <= CAI_RST_DIG_VAL;
    else if (wr && hit_dval) dig_val_ff <= pwdata_i[7:0];
    else if (stop_evt && dig_use_ff[CAI_DIG_COUNT]) dig_val_ff <= dig_val_ff + 8'h01;
  end

  // digital port drive
  wire stat_on = dig_use_ff[CAI_DIG_STATUS];
  wire cnt_on = dig_use_ff[CAI_DIG_COUNT];
  wire [7:0] dig_val_out = {stat_on ? run_ff : dig_val_ff[7], dig_val_ff[6:0]} ^ {8{dig_inv}};
  wire [7:0] dig_en = {stat_on | cnt_on, cnt_on & ~dig_use_ff[CAI_DIG_TRIG], {6{cnt_on}}};
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      dig_out_ff <= 8'h00;
      dig_oe_ff <= 8'h00;
    end else begin
      dig_out_ff <= dig_val_out;
      dig_oe_ff <= dig_en;
    end
  end

  // coincidence inputs; an aux pin being driven is not read as an input
  wire [1:0] aux_lvl = aux_in_i ^ aux_in_ctl_ff[CAI_AUI_POL +: 2];
  wire [1:0] aux_rise = aux_lvl & ~aux_prev_ff & ~aux_oe_ff;
  wire [1:0] aux_start_en = aux_in_ctl_ff[CAI_AUI_START +: 2];
  wire [1:0] aux_coinc_en = aux_in_ctl_ff[CAI_AUI_COINC +: 2];
  wire veto_lvl = veto_i ^ aux_in_ctl_ff[CAI_AUI_VETO_POL];
  wire veto_rise = veto_lvl & ~veto_prev_ff;
  wire veto_coinc = aux_in_ctl_ff[CAI_AUI_VETO_COINC];
  wire veto_late = aux_in_ctl_ff[CAI_AUI_VETO_LATE];
  wire start_hit = run_ff & ((|(conv_hit_i & start_en_ff)) | (|(aux_rise & aux_start_en)));
  wire [NCONV-1:0] cur_conv = seen_conv_ff | conv_hit_i;
  wire [1:0] cur_aux = seen_aux_ff | aux_rise;
  wire cur_veto = seen_veto_ff | veto_rise;
  wire in_idle = st_ff == CAI_ST_IDLE;
  wire in_win = st_ff == CAI_ST_WIN;
  wire in_wait = st_ff == CAI_ST_WAIT;
  wire cnt_last = tick_ff & (cnt_ff <= 16'h0001);
  wire win_end = in_win & cnt_last;
  wire veto_abort = in_win & veto_rise & ~veto_coinc & ~veto_late;
  wire coinc_pass = ((coinc_en_ff & ~cur_conv) == '0) &
                    ((aux_coinc_en & ~cur_aux) == 2'h0) &
                    (veto_coinc ? cur_veto : ~cur_veto);
  wire coinc_ok = win_end & coinc_pass & ~veto_abort;
  wire rdy_all = (wait_mask_ff & ~(rdy_seen_ff | conv_ready_i)) == '0;
  wire wait_tmo = in_wait & ~rdy_all & cnt_last;
  wire win_start = in_idle & start_hit;

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      CAI_ST_IDLE: if (start_hit) nxt_st = CAI_ST_WIN;
      CAI_ST_WIN: begin
        if (veto_abort) nxt_st = CAI_ST_IDLE;
        else if (win_end) nxt_st = coinc_pass ? CAI_ST_WAIT : CAI_ST_IDLE;
      end
      CAI_ST_WAIT: if (rdy_all || wait_tmo) nxt_st = CAI_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_ff <= CAI_ST_IDLE;
      aux_prev_ff <= 2'h0;
      veto_prev_ff <= 1'b0;
      store_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      aux_prev_ff <= aux_lvl;
      veto_prev_ff <= veto_lvl;
      store_ff <= in_wait & rdy_all;
    end
  end

  // counters reload with a snapshot so mid-window writes only affect the next one
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cnt_ff <= 16'h0000;
      len_ff <= 16'h0000;
      ticks_ff <= 16'h0000;
    end else if (win_start) begin
      cnt_ff <= win_len_ff;
      len_ff <= win_len_ff;
      ticks_ff <= 16'h0000;
    end else if (coinc_ok) begin
      cnt_ff <= tmo_len_ff;
      len_ff <= tmo_len_ff;
      ticks_ff <= 16'h0000;
    end else if (tick_ff && !in_idle) begin
      cnt_ff <= cnt_ff - 16'h0001;
      ticks_ff <= ticks_ff + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || win_start) begin
      seen_conv_ff <= reset_i ? '0 : conv_hit_i;
      seen_aux_ff <= reset_i ? 2'h0 : aux_rise;
      seen_veto_ff <= reset_i ? 1'b0 : veto_rise;
    end else if (in_win) begin
      seen_conv_ff <= cur_conv;
      seen_aux_ff <= cur_aux;
      seen_veto_ff <= cur_veto;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wait_mask_ff <= '0;
      rdy_seen_ff <= '0;
    end else if (coinc_ok) begin
      wait_mask_ff <= cur_conv;
      rdy_seen_ff <= '0;
    end else if (in_wait) begin
      rdy_seen_ff <= rdy_seen_ff | conv_ready_i;
    end
  end

  // sticky timeout; a new timeout beats a clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) timeout_ff <= 1'b0;
    else if (wait_tmo) timeout_ff <= 1'b1;
    else if (wr && hit_stat && pwdata_i[CAI_STAT_TIMEOUT]) timeout_ff <= 1'b0;
  end

  // aux output multiplexers, index 0 = aux port two
  for (genvar k = 0; k < 2; k++) begin : g_aux
    wire [3:0] sel = aux_out_ctl_ff[k*CAI_AUO_SEL_W +: CAI_AUO_SEL_W];
    wire mirror = aux_out_ctl_ff[CAI_AUO_MIRROR + k];
    wire [7:0] src = {mirror & run_ff, 1'b1, enc_a_i, in_wait, coinc_ok,
                      !in_idle, in_win, win_start};
    wire drv = sel[3] ? 1'b0 : src[sel[2:0]];
    always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
        aux_drv_ff[k] <= 1'b0;
        aux_oe_ff[k] <= 1'b0;
      end else begin
        aux_drv_ff[k] <= drv;
        aux_oe_ff[k] <= aux_out_ctl_ff[CAI_AUO_OE + k];
      end
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign aux_out_o = aux_drv_ff;
  assign aux_oe_o = aux_oe_ff;
  assign dig_out_o = dig_out_ff;
  assign dig_oe_o = dig_oe_ff;
  assign dig_tristate_o = dig_use_ff[CAI_DIG_TRISTATE];
  assign dig_pulldown_o = dig_use_ff[CAI_DIG_PULLDOWN];
  assign go_o = run_ff;
  assign clear_o = clear_ff;
  assign store_o = store_ff;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_conv_open;
    in_idle && run_ff && (|(conv_hit_i & start_en_ff));
  endsequence
  sequence s_win_entered;
    st_ff == CAI_ST_WIN && ticks_ff == 16'h0000;
  endsequence

  a_win_length: assert property (win_end && len_ff != 16'h0000 |->
    ticks_ff + 16'h0001 == len_ff) else $error("window length wrong");
  a_tmo_length: assert property (wait_tmo && len_ff != 16'h0000 |->
    ticks_ff + 16'h0001 == len_ff) else $error("timeout length wrong");
  a_conv_start: assert property (s_conv_open |=> s_win_entered)
    else $error("converter did not open window");
  a_coinc_miss: assert property (win_end && (|(coinc_en_ff & ~cur_conv)) |=>
    in_idle && !store_o) else $error("missing converter accepted");
  a_aux_polarity: assert property (!aux_oe_ff[0] && aux_in_ctl_ff[CAI_AUI_POL] &&
    $past(aux_in_i[0]) && !aux_in_i[0] && $stable(aux_in_ctl_ff) |-> aux_rise[0])
    else $error("aux two polarity ignored");
  a_aux_start: assert property (in_idle && run_ff && aux_rise[1] && aux_start_en[1]
    |=> s_win_entered) else $error("aux one did not open window");
  a_aux_coinc: assert property (win_end && aux_coinc_en[0] && !cur_aux[0] |=>
    in_idle) else $error("aux two coincidence not required");
  a_veto_coinc: assert property (win_end && veto_coinc && !cur_veto |=> in_idle)
    else $error("veto coincidence not required");
  a_veto_now: assert property (in_win && veto_rise && !veto_coinc && !veto_late
    |=> in_idle) else $error("immediate veto ignored");
  a_src_one: assert property (aux_out_ctl_ff[3:0] == CAI_SRC_ONE |=> aux_out_o[0])
    else $error("aux two constant one missing");
  a_src_enc: assert property (aux_out_ctl_ff[7:4] == CAI_SRC_ENC_A |=>
    aux_out_o[1] == $past(enc_a_i)) else $error("aux one encoder source wrong");
  a_mirror_go: assert property (aux_out_ctl_ff[3:0] == CAI_SRC_ZERO &&
    aux_out_ctl_ff[CAI_AUO_MIRROR] |=> aux_out_o[0] == $past(run_ff))
    else $error("aux two does not mirror run gate");
  a_dig_status: assert property (stat_on |=> dig_oe_o[CAI_DIG_STAT_LINE] &&
    dig_out_o[CAI_DIG_STAT_LINE] == ($past(run_ff) ^ $past(dig_inv)))
    else $error("status line wrong");
  a_dig_trigger: assert property (hw_start && !sw_stop |=> run_ff ##0
    clear_o == $past(dig_use_ff[CAI_DIG_CLR])) else $error("trigger start wrong");
  a_dig_count: assert property ($fell(run_ff) && $past(cnt_on) &&
    !$past(wr && hit_dval) |-> dig_val_ff == $past(dig_val_ff) + 8'h01)
    else $error("output value not incremented");
  a_preset_stop: assert property (run_ff && preset_hit |=> !run_ff)
    else $error("preset did not stop run");
  a_tick_rate: assert property (tick_ff |=> !tick_ff ##1 tick_ff)
    else $error("tick not every 50 ns");
endmodule
`default_nettype wire

/* dv/cai_conv_model.sv */
// converter model: one event pulse, then a data-ready pulse after a gap
// assumes the bench pulses fire_i for one cycle; a gap of 0 means never ready
`timescale 1ns/1ps
`default_nettype none
module cai_conv_model (
  input wire logic sys_clk_i,
  input wire logic fire_i,
  input wire logic [7:0] ready_gap_i,
  output logic hit_o,
  output logic ready_o
);
  logic [7:0] cnt_ff = 8'h00;
  initial hit_o = 1'b0;
  initial ready_o = 1'b0;
  // ready comes long after the hit so the window has closed first
  always @(posedge sys_clk_i) begin
    hit_o <= fire_i;
    ready_o <= (cnt_ff == 8'h01);
    if (fire_i) begin
      cnt_ff <= ready_gap_i;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the coincidence / aux / digital-port block
// assumes an APB master in this bench and a converter model on channel 0
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench import cai_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, fire = 1'b0, hit, rdy, go, store, dig_tri, dig_pd, clr;
  logic [7:0] gap = 8'h00, dig_out, dig_oe, din = 8'h00;
  logic [1:0] aux_out, aux_oe;
  int failures = 0, tests_run = 0, n;
  initial begin
    forever #12.5 clk = ~clk;
  end
  cai_conv_model partner (.sys_clk_i(clk), .fire_i(fire), .ready_gap_i(gap),
    .hit_o(hit), .ready_o(rdy));
  cai_top #(.NCONV(16), .SEC_CYCLES(8)) dut (.sys_clk_i(clk), .reset_i(rst),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .conv_hit_i({15'h0000, hit}), .conv_ready_i({15'h0000, rdy}), .enc_a_i(1'b0),
    .veto_i(1'b0), .aux_in_i(2'b00), .aux_out_o(aux_out), .aux_oe_o(aux_oe),
    .dig_in_i(din), .dig_out_o(dig_out), .dig_oe_o(dig_oe), .dig_tristate_o(dig_tri),
    .dig_pulldown_o(dig_pd), .go_o(go), .clear_o(clr), .store_o(store));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one idle edge first, so a release never meets the next setup in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin failures++; summarize(); end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic pulse_hit(input logic [7:0] g);
    gap <= g; fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  task automatic t_reset();
    apb(1'b0, CAI_OFF_WIN_LEN, 32'h0); `CHK(q, 32'h0000_0050)
    apb(1'b0, CAI_OFF_TMO_LEN, 32'h0); `CHK(q, 32'h0000_0fa0)
    apb(1'b0, CAI_OFF_AUX_IN, 32'h0); `CHK(q, 32'h0000_a003)
    apb(1'b0, 12'h030, 32'h0); `CHK(e, 1'b1)
  endtask
  // window seen on aux port two (code 1) lasts four 50 ns ticks
  task automatic t_window();
    wr(CAI_OFF_AUX_IN, 32'h0);
    wr(CAI_OFF_WIN_LEN, 32'h4);
    wr(CAI_OFF_START_EN, 32'h1);
    wr(CAI_OFF_AUX_OUT, 32'h0101);
    wr(CAI_OFF_RUN_CTL, 32'h10);
    repeat (2) @(posedge clk);
    `CHK(go, 1'b1)
    `CHK(aux_oe, 2'b01)
    pulse_hit(8'd40);
    n = 0;
    repeat (3) @(posedge clk);
    while (aux_out[0] === 1'b1 && n < 50) begin @(posedge clk); n++; end
    `CHK(n >= 6 && n <= 8, 1'b1)
    n = 0;
    while (store !== 1'b1 && n < 60) begin @(posedge clk); n++; end
    `CHK(store, 1'b1)
  endtask
  // no data ready: the wait gives up after three ticks and flags it
  task automatic t_timeout();
    wr(CAI_OFF_TMO_LEN, 32'h3);
    pulse_hit(8'd0);
    repeat (30) @(posedge clk);
    apb(1'b0, CAI_OFF_STATUS, 32'h0); `CHK(q[CAI_STAT_TIMEOUT], 1'b1)
  endtask
  task automatic t_mirror_count();
    wr(CAI_OFF_AUX_OUT, 32'h0a70);
    wr(CAI_OFF_DIG_VAL, 32'h5);
    wr(CAI_OFF_DIG_USE, 32'h41);
    repeat (2) @(posedge clk);
    `CHK(aux_out[1], 1'b1)
    `CHK(aux_oe, 2'b10)
    `CHK(dig_out[7], 1'b1)
    `CHK(dig_out[5:0], 6'h05)
    wr(CAI_OFF_RUN_CTL, 32'h20);
    repeat (3) @(posedge clk);
    `CHK(aux_out[1], 1'b0)
    apb(1'b0, CAI_OFF_DIG_VAL, 32'h0); `CHK(q, 32'h0000_0006)
  endtask
  // one second is shortened to 8 cycles, so a preset of 2 runs about 16
  task automatic t_preset();
    wr(CAI_OFF_RUN_CTL, 32'h40);
    wr(CAI_OFF_RT_PRESET, 32'h2);
    wr(CAI_OFF_RUN_CTL, 32'h11);
    // go only settles after the edge that lands the start write
    @(posedge clk);
    n = 0;
    while (go !== 1'b0 && n < 100) begin @(posedge clk); n++; end
    `CHK(n >= 12 && n <= 18, 1'b1)
    apb(1'b0, CAI_OFF_ELAPSED, 32'h0); `CHK(q, 32'h0000_0002)
  endtask
  // line 6 rising starts a stopped run and clears in the same cycle; termination pins follow bits 7/8
  task automatic t_trigger();
    wr(CAI_OFF_DIG_USE, 32'h1cc);
    repeat (2) @(posedge clk);
    `CHK(dig_tri, 1'b1)
    `CHK(dig_pd, 1'b1)
    `CHK(dig_oe, 8'hbf)
    `CHK(go, 1'b0)
    din <= 8'h40;
    repeat (2) @(posedge clk);
    `CHK(go, 1'b1)
    `CHK(clr, 1'b1)
    apb(1'b0, CAI_OFF_ELAPSED, 32'h0); `CHK(q, 32'h0000_0000)
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_window();
    t_timeout();
    t_mirror_count();
    t_preset();
    t_trigger();
    summarize();
  end
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
